// *** verilog/ipt_target_port.sv ***
// I2C target port with CRC-8 packet checking, staged registers and straps.
// SCL, SDA, straps and dimming pin comparators are asynchronous pins.
// Fault events and generator outputs come from logic on mclk.
`timescale 1ns/1ps
`default_nettype none
module ipt_target_port import ipt_pkg::*; (
    input wire logic mclk, // System clock, 100 MHz
    input wire logic reset_n, // Async reset, active low
    input wire logic sclIn, // Bus clock pin
    input wire logic sdaIn, // Bus data pin level
    output logic sdaOut, // Bus data drive value, always low
    output logic sdaOe, // High while pulling data low
    input wire logic [1:0] addrStrapLow, // Low strap three-state code
    input wire logic [1:0] addrStrapHigh, // High strap three-state code
    input wire logic [NUM_CH-1:0] pwmOffReq, // Dimming pin below 0.1V
    input wire logic [NUM_CH-1:0] zeroCurReq, // Dimming pin below 0.2V
    input wire logic [NUM_CH-1:0][7:0] pinThreshold, // Pin-derived threshold
    input wire logic [NUM_CH-1:0] faultEvent, // Fault detected, level
    input wire logic [NUM_CH-1:0] dimGenPwm, // Dimming generator output
    output logic strapValid, // Straps captured
    output logic standalone, // Standalone mode
    output logic [3:0] addrSel, // Captured address bits
    output logic [NUM_CH-1:0] chanEnable, // Channel enables
    output logic [NUM_CH-1:0] dimGenEnable, // Dimming generator enables
    output logic [NUM_CH-1:0][7:0] dutyCode, // Active duty codes
    output logic [NUM_CH-1:0] ledGate, // Final light-on gate
    output logic [NUM_CH-1:0][7:0] senseThreshold, // Scaled threshold
    output logic [NUM_CH-1:0] faultStatus, // Latched fault bits
    output logic alertOut, // Alert drive value, always low
    output logic alertOe // High while pulling alert low
);
    logic sclMeta, sclSync, sclPrev, sdaMeta, sdaSync, sdaPrev;
    logic [3:0] strapMeta, strapSync;
    logic [NUM_CH-1:0] offMeta, offSync, zeroMeta, zeroSync;
    logic [1:0] settle, next_settle;
    logic next_strapValid, next_standalone;
    logic [3:0] next_addrSel;
    ipt_state_t state, next_state;
    logic [2:0] bitCnt, next_bitCnt, byteIdx, next_byteIdx;
    logic [7:0] shreg, next_shreg, txShift, next_txShift;
    logic [7:0] ptr, next_ptr, dataByte, next_dataByte;
    logic [7:0] crc, next_crc, rdByte, crcRx;
    logic rwRead, next_rwRead, txIdx, next_txIdx, sdaDrive, next_sdaDrive;
    logic [7:0] regs [NUM_RW];
    logic [7:0] next_regs [NUM_RW];
    logic [7:0] stageVal [NUM_REG];
    logic [7:0] next_stageVal [NUM_REG];
    logic [NUM_REG-1:0] stagePend, next_stagePend;
    logic [NUM_CH-1:0] next_faultStatus, statusClr, next_ledGate;
    logic next_alert;
    logic startDet, stopDet, sclRise, sclFall, busOn;
    ipt_chcfg_t cfg;

    function automatic logic [7:0] crc8Byte(input logic [7:0] crcIn, input logic [7:0] dataIn);
        logic [7:0] c;
        c = crcIn ^ dataIn;
        for (int i = 0; i < 8; i++) begin
            if (c[7]) begin
                c = {c[6:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        return c;
    endfunction

    function automatic logic [1:0] strapBits(input logic [1:0] s);
        if (s == STRAP_VCC) begin
            return STRAP_BITS_VCC;
        end else if (s == STRAP_FLOAT) begin
            return STRAP_BITS_FLOAT;
        end
        return STRAP_BITS_GND;
    endfunction

    // Pin synchronisers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sclMeta <= 1'b1;
            sclSync <= 1'b1;
            sclPrev <= 1'b1;
            sdaMeta <= 1'b1;
            sdaSync <= 1'b1;
            sdaPrev <= 1'b1;
            strapMeta <= '0;
            strapSync <= '0;
            offMeta <= '0;
            offSync <= '0;
            zeroMeta <= '0;
            zeroSync <= '0;
        end else begin
            sclMeta <= sclIn;
            sclSync <= sclMeta;
            sclPrev <= sclSync;
            sdaMeta <= sdaIn;
            sdaSync <= sdaMeta;
            sdaPrev <= sdaSync;
            strapMeta <= {addrStrapHigh, addrStrapLow};
            strapSync <= strapMeta;
            offMeta <= pwmOffReq;
            offSync <= offMeta;
            zeroMeta <= zeroCurReq;
            zeroSync <= zeroMeta;
        end
    end

    assign cfg = ipt_chcfg_t'(regs[PTR_CHCFG[3:0]]);
    assign startDet = sclSync & sclPrev & sdaPrev & ~sdaSync;
    assign stopDet = sclSync & sclPrev & ~sdaPrev & sdaSync;
    assign sclRise = sclSync & ~sclPrev;
    assign sclFall = ~sclSync & sclPrev;
    assign busOn = strapValid & ~standalone;
    assign crcRx = crc8Byte(crc, shreg);

    always_comb begin
        rdByte = 8'h00;
        if (ptr == PTR_STATUS) begin
            rdByte = {4'h0, faultStatus};
        end else if (ptr < NUM_RW[7:0]) begin
            rdByte = regs[ptr[3:0]];
        end
    end

    always_comb begin
        next_settle = settle;
        next_strapValid = strapValid;
        next_standalone = standalone;
        next_addrSel = addrSel;
        next_state = state;
        next_bitCnt = bitCnt;
        next_byteIdx = byteIdx;
        next_shreg = shreg;
        next_txShift = txShift;
        next_ptr = ptr;
        next_dataByte = dataByte;
        next_crc = crc;
        next_rwRead = rwRead;
        next_txIdx = txIdx;
        next_sdaDrive = sdaDrive;
        next_regs = regs;
        next_stageVal = stageVal;
        next_stagePend = stagePend;
        statusClr = '0;
        // Straps caught once after reset release
        if (!strapValid) begin
            next_settle = settle + 2'h1;
            if (settle == STRAP_SETTLE) begin
                next_strapValid = 1'b1;
                next_addrSel = {strapBits(strapSync[3:2]), strapBits(strapSync[1:0])};
                next_standalone = (strapSync == {STRAP_GND, STRAP_GND});
            end
        end
        if (!busOn) begin
            next_state = S_IDLE;
            next_sdaDrive = 1'b0;
        end else if (startDet) begin
            next_state = S_RX;
            next_bitCnt = '0;
            next_byteIdx = IDX_ADDR;
            next_crc = CRC_INIT;
            next_rwRead = 1'b0;
            next_sdaDrive = 1'b0;
        end else if (stopDet) begin
            next_state = S_IDLE;
            next_sdaDrive = 1'b0;
            for (int i = 0; i < NUM_RW; i++) begin
                if (stagePend[i]) begin
                    next_regs[i] = stageVal[i];
                end
            end
            if (stagePend[PTR_STATUS[3:0]]) begin
                statusClr = stageVal[PTR_STATUS[3:0]][NUM_CH-1:0];
            end
            next_stagePend = '0;
        end else begin
            case (state)
                S_RX: begin
                    if (sclRise) begin
                        next_shreg = {shreg[6:0], sdaSync};
                        next_bitCnt = bitCnt + 3'h1;
                        if (bitCnt == 3'h7) begin
                            next_state = S_EVAL;
                        end
                    end
                end
                S_EVAL: begin
                    if (sclFall) begin
                        next_state = S_ACK;
                        next_sdaDrive = 1'b1;
                        case (byteIdx)
                            IDX_ADDR: begin
                                next_crc = crcRx;
                                next_rwRead = shreg[0];
                                if (shreg[7:1] != {ADDR_PREFIX, addrSel}) begin
                                    next_state = S_IGNORE;
                                    next_sdaDrive = 1'b0;
                                end
                            end
                            IDX_PTR: begin
                                next_ptr = shreg;
                                next_crc = crcRx;
                            end
                            IDX_DATA: begin
                                next_dataByte = shreg;
                                next_crc = crcRx;
                            end
                            IDX_PEC: begin
                                if (shreg == crc) begin
                                    if (ptr < NUM_REG[7:0]) begin
                                        next_stageVal[ptr[3:0]] = dataByte;
                                        next_stagePend[ptr[3:0]] = 1'b1;
                                    end
                                end else begin
                                    next_state = S_IGNORE;
                                    next_sdaDrive = 1'b0;
                                end
                            end
                            default: begin
                                next_state = S_IGNORE;
                                next_sdaDrive = 1'b0;
                            end
                        endcase
                    end
                end
                S_ACK: begin
                    if (sclFall) begin
                        next_bitCnt = '0;
                        next_byteIdx = byteIdx + 3'h1;
                        next_sdaDrive = 1'b0;
                        next_state = S_RX;
                        if (rwRead) begin
                            next_crc = crc8Byte(crc, rdByte);
                            next_txShift = rdByte;
                            next_sdaDrive = ~rdByte[7];
                            next_txIdx = 1'b0;
                            next_state = S_TX;
                        end
                    end
                end
                S_TX: begin
                    if (sclFall) begin
                        if (bitCnt == 3'h7) begin
                            next_sdaDrive = 1'b0;
                            next_state = S_TXACK;
                        end else begin
                            next_txShift = {txShift[6:0], 1'b0};
                            next_sdaDrive = ~txShift[6];
                            next_bitCnt = bitCnt + 3'h1;
                        end
                    end
                end
                S_TXACK: begin
                    if (sclRise) begin
                        next_state = (!sdaSync && !txIdx) ? S_TXNEXT : S_IGNORE;
                    end
                end
                S_TXNEXT: begin
                    if (sclFall) begin
                        next_txShift = crc;
                        next_sdaDrive = ~crc[7];
                        next_bitCnt = '0;
                        next_txIdx = 1'b1;
                        next_state = S_TX;
                    end
                end
                S_IDLE, S_IGNORE: begin
                    next_sdaDrive = 1'b0;
                end
                default: begin
                    next_state = S_IDLE;
                    next_sdaDrive = 1'b0;
                end
            endcase
        end
        next_faultStatus = standalone ? '0 : ((faultStatus & ~statusClr) | faultEvent);
        next_alert = standalone ? |faultEvent : |(faultStatus & regs[PTR_MASK[3:0]][NUM_CH-1:0]);
        for (int ch = 0; ch < NUM_CH; ch++) begin
            next_ledGate[ch] = chanEnable[ch] & ~offSync[ch]
                & (~dimGenEnable[ch] | (dimGenPwm[ch] & (regs[ch] != 8'h00)));
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            settle <= '0;
            strapValid <= 1'b0;
            standalone <= 1'b0;
            addrSel <= '0;
            state <= S_IDLE;
            bitCnt <= '0;
            byteIdx <= '0;
            shreg <= '0;
            txShift <= '0;
            ptr <= '0;
            dataByte <= '0;
            crc <= CRC_INIT;
            rwRead <= 1'b0;
            txIdx <= 1'b0;
            sdaDrive <= 1'b0;
            // Duty zero, channels and generators on
            for (int i = 0; i < NUM_CH; i++) begin
                regs[i] <= DUTY_RST;
                regs[i + NUM_CH] <= ANALOG_DIM_CODE_RST;
            end
            regs[PTR_CHCFG[3:0]] <= CHCFG_RST;
            regs[PTR_MASK[3:0]] <= MASK_RST;
            for (int i = 0; i < NUM_REG; i++) begin
                stageVal[i] <= '0;
            end
            stagePend <= '0;
            faultStatus <= '0;
            alertOe <= 1'b0;
            ledGate <= '0;
        end else begin
            settle <= next_settle;
            strapValid <= next_strapValid;
            standalone <= next_standalone;
            addrSel <= next_addrSel;
            state <= next_state;
            bitCnt <= next_bitCnt;
            byteIdx <= next_byteIdx;
            shreg <= next_shreg;
            txShift <= next_txShift;
            ptr <= next_ptr;
            dataByte <= next_dataByte;
            crc <= next_crc;
            rwRead <= next_rwRead;
            txIdx <= next_txIdx;
            sdaDrive <= next_sdaDrive;
            regs <= next_regs;
            stageVal <= next_stageVal;
            stagePend <= next_stagePend;
            faultStatus <= next_faultStatus;
            alertOe <= next_alert;
            ledGate <= next_ledGate;
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOe = sdaDrive;
    assign alertOut = 1'b0;
    // Standalone forces channels on, generators off
    assign chanEnable = strapValid ? (standalone ? '1 : cfg.chanOn) : '0;
    assign dimGenEnable = busOn ? cfg.dimGenOn : '0;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gScale
            assign dutyCode[g] = regs[g];
            ipt_threshold_scaler #(.W(DATA_W)) uScale (
                .mclk(mclk),
                .reset_n(reset_n),
                .pinThreshold(pinThreshold[g]),
                .analogDimCode(regs[g + NUM_CH]),
                .zeroCurrent(zeroSync[g]),
                .scaled(senseThreshold[g])
            );
        end
    endgenerate
endmodule
`default_nettype wire

// *** verilog/ipt_pkg.sv ***
// Constants, field layouts and shared types for the I2C target port with
// CRC-8 packet error checking. Assumes one 100 MHz system clock domain.
package ipt_pkg;
    localparam int NUM_CH = 4;
    localparam int DATA_W = 8;
    localparam logic [2:0] ADDR_PREFIX = 3'h5;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    // Three-state strap codes from the pin sensing front end
    localparam logic [1:0] STRAP_GND = 2'h0;
    localparam logic [1:0] STRAP_FLOAT = 2'h1;
    localparam logic [1:0] STRAP_VCC = 2'h2;
    localparam logic [1:0] STRAP_BITS_GND = 2'h0;
    localparam logic [1:0] STRAP_BITS_FLOAT = 2'h1;
    localparam logic [1:0] STRAP_BITS_VCC = 2'h3;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    // Register pointer map
    localparam logic [7:0] PTR_DUTY0 = 8'h00;
    localparam logic [7:0] PTR_ADIM0 = 8'h04;
    localparam logic [7:0] PTR_CHCFG = 8'h08;
    localparam logic [7:0] PTR_MASK = 8'h09;
    localparam logic [7:0] PTR_STATUS = 8'h0a;
    localparam int NUM_RW = 10;
    localparam int NUM_REG = 11;
    // Reset values
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [7:0] ANALOG_DIM_CODE_RST = 8'hff;
    localparam logic [7:0] CHCFG_RST = 8'hff;
    localparam logic [7:0] MASK_RST = 8'h00;
    // Byte positions within a transaction
    localparam logic [2:0] IDX_ADDR = 3'h0;
    localparam logic [2:0] IDX_PTR = 3'h1;
    localparam logic [2:0] IDX_DATA = 3'h2;
    localparam logic [2:0] IDX_PEC = 3'h3;

    typedef struct packed {
        logic [3:0] dimGenOn;
        logic [3:0] chanOn;
    } ipt_chcfg_t;

    typedef enum logic [2:0] {
        S_IDLE, S_RX, S_EVAL, S_ACK, S_TX, S_TXACK, S_TXNEXT, S_IGNORE
    } ipt_state_t;
endpackage

// *** verilog/ipt_threshold_scaler.sv ***
// One channel of the analog dimming threshold scaler.
// Inputs come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ipt_threshold_scaler import ipt_pkg::*; #(
    parameter int W = DATA_W
) (
    input wire logic mclk, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic [W-1:0] pinThreshold, // Pin-derived threshold
    input wire logic [W-1:0] analogDimCode, // Analog dimming code
    input wire logic zeroCurrent, // Pin below zero-current level
    output logic [W-1:0] scaled // Scaled sense threshold
);
    logic [W:0] codePlusOne;
    logic [2*W:0] product;
    logic [W-1:0] next_scaled;

    always_comb begin
        codePlusOne = {1'b0, analogDimCode} + {{W{1'b0}}, 1'b1};
        product = {{W{1'b0}}, pinThreshold} * codePlusOne;
        next_scaled = product[2*W-1:W];
        if (zeroCurrent) begin
            next_scaled = '0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            scaled <= '0;
        end else begin
            scaled <= next_scaled;
        end
    end
endmodule
`default_nettype wire

// *** verif/ipt_target_port_assertions.sv ***
// Port checker for the I2C target port.
// Bound to every ipt_target_port instance.
`timescale 1ns/1ps
`default_nettype none
module ipt_port_checker import ipt_pkg::*; (
    input wire logic mclk, // Clock
    input wire logic reset_n, // Reset
    input wire logic sclIn, // Clock pin
    input wire logic sdaIn, // Data pin
    input wire logic sdaOe, // Data pull
    input wire logic [1:0] addrStrapLow, // Strap
    input wire logic [1:0] addrStrapHigh, // Strap
    input wire logic [NUM_CH-1:0] faultEvent, // Faults
    input wire logic strapValid, // Captured
    input wire logic standalone, // Mode
    input wire logic [3:0] addrSel, // Address
    input wire logic [NUM_CH-1:0] chanEnable, // Enables
    input wire logic [NUM_CH-1:0] dimGenEnable, // Gens
    input wire logic [NUM_CH-1:0][7:0] dutyCode, // Duty
    input wire logic [NUM_CH-1:0] ledGate, // Gate
    input wire logic [NUM_CH-1:0] faultStatus, // Latched
    input wire logic alertOe // Alert
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    function automatic logic [1:0] bits(input logic [1:0] s);
        return s == STRAP_FLOAT ? STRAP_BITS_FLOAT : s == STRAP_VCC ? STRAP_BITS_VCC : STRAP_BITS_GND;
    endfunction
    strap_addr_a: assert property (strapValid [*2] |-> addrSel == {bits(addrStrapHigh), bits(addrStrapLow)})
        else $error("address bits off");
    mode_sel_a: assert property (strapValid [*2] |-> standalone == (addrSel == 4'h0))
        else $error("mode select off");
    alone_cfg_a: assert property (standalone |-> chanEnable == 4'hf && dimGenEnable == 4'h0 && !sdaOe)
        else $error("standalone setup off");
    alone_nolatch_a: assert property (standalone |-> faultStatus == 4'h0)
        else $error("standalone latched");
    alone_alert_a: assert property (standalone && |faultEvent |=> alertOe)
        else $error("standalone alert missing");
    mask_quiet_a: assert property ((strapValid && !standalone && faultStatus == 4'h0) [*2] |-> !alertOe)
        else $error("alert without fault");
    dark_zero_a: assert property ((dutyCode[0] == 8'h00 && dimGenEnable[0]) [*2] |-> !ledGate[0])
        else $error("light at zero duty");
    commit_stop_a: assert property ($changed(dutyCode) |-> sclIn && sdaIn)
        else $error("duty changed off stop");
    cover property (standalone && alertOe);
    cover property ($rose(alertOe) && !standalone);
    cover property ($changed(dutyCode));
endmodule
bind ipt_target_port ipt_port_checker u_chk (.mclk(mclk), .reset_n(reset_n), .sclIn(sclIn), .sdaIn(sdaIn),
    .sdaOe(sdaOe), .addrStrapLow(addrStrapLow), .addrStrapHigh(addrStrapHigh), .faultEvent(faultEvent),
    .strapValid(strapValid), .standalone(standalone), .addrSel(addrSel), .chanEnable(chanEnable),
    .dimGenEnable(dimGenEnable), .dutyCode(dutyCode), .ledGate(ledGate), .faultStatus(faultStatus),
    .alertOe(alertOe));
`default_nettype wire

// *** verif/ipt_host_model.sv ***
// I2C host model with packet error codes.
// Open-drain data; the bench resolves the wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module ipt_host_model (
    output logic scl, // Bus clock
    output logic sdaLow, // Pulls data low
    input wire logic sda // Resolved data
);
    logic rd;
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        c = c ^ d;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
        end
        return c;
    endfunction
    task automatic bitx(input logic b, output logic r);
        #20 sdaLow = !b;
        #20 scl = 1'b1;
        #20 r = sda;
        #20 scl = 1'b0;
    endtask
    task automatic start();
        #40 sdaLow = 1'b0;
        #40 scl = 1'b1;
        #40 sdaLow = 1'b1;
        #40 scl = 1'b0;
    endtask
    task automatic stop();
        #20 sdaLow = 1'b1;
        #40 scl = 1'b1;
        #40 sdaLow = 1'b0;
        #100;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bitx(b[i], rd);
        end
        bitx(1'b1, rd);
        ack = !rd;
    endtask
    task automatic rbyte(input logic more, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, b[i]);
        end
        bitx(!more, rd);
    endtask
    task automatic wtxn(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d, input logic bad,
        output logic ok);
        logic k0, k1, k2, k3;
        start();
        wbyte(a, k0);
        wbyte(p, k1);
        wbyte(d, k2);
        wbyte(crc8(crc8(crc8(8'h00, a), p), d) ^ {7'h0, bad}, k3);
        ok = k0 & k1 & k2 & k3;
    endtask
    task automatic rtxn(input logic [7:0] a, input logic [7:0] p, input logic sr, output logic [7:0] d,
        output logic pecOk);
        logic k;
        logic [7:0] pec;
        start();
        wbyte(a, k);
        wbyte(p, k);
        if (!sr) begin
            stop();
        end
        start();
        wbyte(a | 8'h01, k);
        rbyte(1'b1, d);
        rbyte(1'b0, pec);
        stop();
        pecOk = pec == crc8(crc8(8'h00, a | 8'h01), d);
    endtask
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Bench for the I2C target port: host model on the bus,
// pin-side inputs driven here at the falling clock edge.
`timescale 1ns/1ps
`default_nettype none
module tb import ipt_pkg::*;;
    logic mclk, reset_n, sdaOe, scl, hostLow, strapValid, standalone, alertOe, ok, pecOk, sdaOut, alertOut;
    logic [1:0] strapLo, strapHi;
    logic [3:0] pwmOff, zeroCur, fault, pwmGen, addrSel, chanEnable, dimGenEnable, ledGate, faultStatus;
    logic [3:0][7:0] pinThr, dutyCode, senseThr;
    logic [7:0] rdata;
    logic [7:0] wdat [4] = '{8'h33, 8'h44, 8'h66, 8'h55};
    int num_errors, num_checks;
    wire logic sda = !(hostLow || sdaOe);
    ipt_target_port DUT (.mclk(mclk), .reset_n(reset_n), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .addrStrapLow(strapLo), .addrStrapHigh(strapHi), .pwmOffReq(pwmOff), .zeroCurReq(zeroCur),
        .pinThreshold(pinThr), .faultEvent(fault), .dimGenPwm(pwmGen), .strapValid(strapValid),
        .standalone(standalone), .addrSel(addrSel), .chanEnable(chanEnable), .dimGenEnable(dimGenEnable),
        .dutyCode(dutyCode), .ledGate(ledGate), .senseThreshold(senseThr), .faultStatus(faultStatus),
        .alertOut(alertOut), .alertOe(alertOe));
    ipt_host_model host (.scl(scl), .sdaLow(hostLow), .sda(sda));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = !mclk;
    end
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic boot(input logic [1:0] hi, input logic [1:0] lo);
        int n;
        @(negedge mclk);
        reset_n = 1'b0;
        strapHi = hi;
        strapLo = lo;
        repeat (5) @(negedge mclk);
        reset_n = 1'b1;
        n = 0;
        while (strapValid !== 1'b1 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        if (n == 50) begin
            num_errors++;
            wrap_up();
        end
        repeat (10) @(negedge mclk);
    endtask
    initial begin
        reset_n = 1'b0;
        strapLo = STRAP_FLOAT;
        strapHi = STRAP_GND;
        pwmOff = 4'h0;
        zeroCur = 4'h0;
        fault = 4'h0;
        pwmGen = 4'h0;
        pinThr = {4{8'hc8}};
        boot(STRAP_GND, STRAP_FLOAT);
        chk("addrSel", 32'h1, addrSel);
        chk("normal setup", 32'h000ff000, {standalone, chanEnable, dimGenEnable, dutyCode[0], ledGate});
        chk("pin levels", 32'h4, {strapValid, sdaOut, alertOut});
        for (int i = 0; i < 4; i++) begin
            host.wtxn(8'ha2, i[7:0], wdat[i], i == 2, ok);
            chk("write ack", {31'h0, i != 2}, ok);
        end
        chk("staged", 32'h0, dutyCode);
        host.stop();
        chk("committed", 32'h55004433, dutyCode);
        host.wtxn(8'ha4, PTR_DUTY0, 8'h11, 1'b0, ok);
        host.stop();
        chk("foreign", 32'h0, {31'h0, ok});
        chk("foreign data", 32'h55004433, dutyCode);
        for (int m = 0; m < 2; m++) begin
            host.rtxn(8'ha2, m ? 8'h03 : 8'h01, m == 0, rdata, pecOk);
            chk("read data", m ? 32'h55 : 32'h44, rdata);
            chk("read pec", 32'h1, pecOk);
        end
        @(negedge mclk);
        pwmGen = 4'hf;
        repeat (3) @(negedge mclk);
        chk("gate duty", 32'hb, ledGate);
        host.wtxn(8'ha2, PTR_CHCFG, 8'h0f, 1'b0, ok);
        host.stop();
        pwmGen = 4'h0;
        pwmOff = 4'h8;
        repeat (6) @(negedge mclk);
        chk("gate full", 32'h07, {dimGenEnable, ledGate});
        host.wtxn(8'ha2, PTR_ADIM0, 8'h7f, 1'b0, ok);
        host.stop();
        zeroCur = 4'h2;
        repeat (6) @(negedge mclk);
        chk("threshold", 32'hc8c80064, senseThr);
        fault = 4'h2;
        @(negedge mclk);
        fault = 4'h0;
        repeat (3) @(negedge mclk);
        chk("fault masked", 32'h02, {alertOe, faultStatus});
        host.wtxn(8'ha2, PTR_MASK, 8'h02, 1'b0, ok);
        host.stop();
        chk("fault shown", 32'h12, {alertOe, faultStatus});
        host.wtxn(8'ha2, PTR_STATUS, 8'h02, 1'b0, ok);
        host.stop();
        chk("fault cleared", 32'h0, {alertOe, faultStatus});
        boot(STRAP_VCC, STRAP_FLOAT);
        chk("addrSel high", 32'hd, {standalone, addrSel});
        boot(STRAP_GND, STRAP_GND);
        chk("alone setup", 32'h1f07, {standalone, chanEnable, dimGenEnable, ledGate});
        host.wtxn(8'ha0, PTR_DUTY0, 8'h11, 1'b0, ok);
        host.stop();
        chk("alone bus", 32'h0, {31'h0, ok});
        fault = 4'h1;
        repeat (2) @(negedge mclk);
        chk("alone alert", 32'h10, {alertOe, faultStatus});
        fault = 4'h0;
        repeat (2) @(negedge mclk);
        chk("alone release", 32'h0, alertOe);
        wrap_up();
    end
endmodule
`default_nettype wire
